// ---- src/scig_top.sv ----
// System-control register bank: interrupt sources, fast-bus port select, regulator, clock gating
//
// Function
// - A port whose fast-bus path is off is served only through the peripheral bus aperture.
// - A port whose fast-bus path is on is served only at its separate fast-bus base.
// - Three interrupt sources exist as separate bits: oscillator power-up, synthesiser lock, brown-out.
// - A clear with a mask deasserts each selected pending source and leaves the others; a new event in the same cycle keeps its bit set.
// - An enable mask sets the selected enable bits and keeps the others.
// - A disable mask clears the selected enable bits and keeps the others.
// - Only enabled pending sources drive the interrupt line.
// - Status reads give raw pending or pending ANDed with enables, as the requester chooses.
// - The regulator setting is read and written, defaults to 2.5 V and spans +/-10% in 0.05 V steps.
// - With gating off, the reset default, peripherals run in sleep modes as in run mode.
// - With gating on, sleep and deep-sleep clocks follow separate per-peripheral enables.
// - Clearing a deep-sleep enable stops that clock in deep-sleep when gating is on.
// - A run-enabled peripheral stopped in deep-sleep resumes on wake with its state kept.
// - Deep-sleep settings are kept while gating is off but then have no effect.
//
// The strobed register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "scig_defs.svh"
module scig_top
  import scig_pkg::*;
#(
  parameter int NUM_PERIPH = 32,
  parameter int NUM_PORTS  = 8
) (
  input  wire logic                  i_clock,
  input  wire logic                  i_nrst,
  // Register port
  input  wire logic [7:0]            i_addr,
  input  wire logic [31:0]           i_wdata,
  input  wire logic                  i_wr,
  input  wire logic                  i_rd,
  output logic [31:0]                o_rdata,
  // Interrupt events, one-cycle pulses or levels
  input  wire logic                  i_main_osc_powerup_irq,
  input  wire logic                  i_freq_synth_lock_irq,
  input  wire logic                  i_brownout_irq,
  output logic                       o_irq,
  // Processor power mode
  input  wire logic                  i_sleep,
  input  wire logic                  i_deep_sleep,
  // GPIO port access requests from each bus, decoded per port
  input  wire logic [NUM_PORTS-1:0]  i_port_apb_sel,
  input  wire logic [NUM_PORTS-1:0]  i_port_ahb_sel,
  output logic [NUM_PORTS-1:0]       o_port_apb_grant,
  output logic [NUM_PORTS-1:0]       o_port_ahb_grant,
  output logic [NUM_PORTS-1:0]       o_port_fast_path,
  // Regulator and peripheral clocks
  output logic [`SCIG_REG_W-1:0]     o_regulator_setting,
  output logic [NUM_PERIPH-1:0]      o_periph_clk_en
);
  localparam logic [NUM_PORTS-1:0] FAST_CAPABLE = NUM_PORTS'(`SCIG_FAST_CAPABLE);

  logic [`SCIG_IRQ_W-1:0] pending_q;
  logic [`SCIG_IRQ_W-1:0] enable_q;
  logic [NUM_PORTS-1:0]   fast_q;
  logic [`SCIG_REG_W-1:0] regulator_q;
  logic                   gating_q;
  logic                   view_q;
  logic [NUM_PERIPH-1:0]  run_en_q;
  logic [NUM_PERIPH-1:0]  sleep_en_q;
  logic [NUM_PERIPH-1:0]  dsleep_en_q;
  logic [31:0]            rdata_q;
  logic [`SCIG_IRQ_W-1:0] events;
  logic [`SCIG_IRQ_W-1:0] masked;
  logic [`SCIG_IRQ_W-1:0] pending_d;
  logic [`SCIG_IRQ_W-1:0] enable_d;
  logic [NUM_PORTS-1:0]   fast_d;
  logic [31:0]            rdata_d;
  scig_bus_op_t           bus_op;
  scig_power_mode_t       power_mode;
  logic                   wr_clear;
  logic                   wr_enable;
  logic                   wr_ena_set;
  logic                   wr_ena_clr;
  logic                   wr_fast;
  logic                   wr_regulator;
  logic                   wr_gating;
  logic                   wr_view;
  logic                   wr_run_en;
  logic                   wr_sleep_en;
  logic                   wr_dsleep_en;
  logic                   fast_ok;
  logic                   reg_ok;

  scig_gate_if #(.NUM_PERIPH(NUM_PERIPH)) gate_bus ();

  // Write strobe decode for one register offset
  function automatic logic wr_hit(input scig_bus_op_t op, input logic [7:0] addr, input logic [7:0] off);
    return (op == SCIG_BUS_WRITE) && (addr == off);
  endfunction

  // Place a narrow field in the low bits of a read word
  function automatic logic [31:0] zext_irq(input logic [`SCIG_IRQ_W-1:0] v);
    return {{(32 - `SCIG_IRQ_W){1'b0}}, v};
  endfunction

  // Check that a write names exactly one port that has a fast path
  function automatic logic one_fast_port(input logic [NUM_PORTS-1:0] m);
    return ($countones(m) == 1) && ((m & ~FAST_CAPABLE) == '0);
  endfunction

  assign events = {i_brownout_irq, i_freq_synth_lock_irq, i_main_osc_powerup_irq};
  assign masked = pending_q & enable_q;

  // Bus operation of this cycle; write wins should both strobes ever meet
  always_comb begin
    if (i_wr) begin
      bus_op = SCIG_BUS_WRITE;
    end else if (i_rd) begin
      bus_op = SCIG_BUS_READ;
    end else begin
      bus_op = SCIG_BUS_IDLE;
    end
  end

  // Write strobes, one per register offset
  assign wr_clear     = wr_hit(bus_op, i_addr, `SCIG_OFF_IRQ_CLEAR);
  assign wr_enable    = wr_hit(bus_op, i_addr, `SCIG_OFF_IRQ_ENABLE);
  assign wr_ena_set   = wr_hit(bus_op, i_addr, `SCIG_OFF_IRQ_ENA_SET);
  assign wr_ena_clr   = wr_hit(bus_op, i_addr, `SCIG_OFF_IRQ_ENA_CLR);
  assign wr_fast      = wr_hit(bus_op, i_addr, `SCIG_OFF_FAST_BUS);
  assign wr_regulator = wr_hit(bus_op, i_addr, `SCIG_OFF_REGULATOR);
  assign wr_gating    = wr_hit(bus_op, i_addr, `SCIG_OFF_GATING);
  assign wr_view      = wr_hit(bus_op, i_addr, `SCIG_OFF_STATUS_VIEW);
  assign wr_run_en    = wr_hit(bus_op, i_addr, `SCIG_OFF_RUN_EN);
  assign wr_sleep_en  = wr_hit(bus_op, i_addr, `SCIG_OFF_SLEEP_EN);
  assign wr_dsleep_en = wr_hit(bus_op, i_addr, `SCIG_OFF_DSLEEP_EN);

  // Writes whose argument is legal; any other leaves the state alone
  assign fast_ok = wr_fast && one_fast_port(i_wdata[NUM_PORTS-1:0]);
  assign reg_ok  = wr_regulator && (i_wdata[31:`SCIG_REG_W] == '0)
                   && (i_wdata[`SCIG_REG_W-1:0] <= `SCIG_REG_MAX);

  // Pending next state: events set, a clear mask drops selected bits; set wins over clear
  always_comb begin
    pending_d = pending_q | events;
    if (wr_clear) begin
      pending_d = (pending_q & ~i_wdata[`SCIG_IRQ_W-1:0]) | events;
    end
  end

  // Pending interrupt bits
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      pending_q <= '0;
    end else begin
      pending_q <= pending_d;
    end
  end

  // Enable next state: direct write, set mask or clear mask
  always_comb begin
    enable_d = enable_q;
    if (wr_enable) begin
      enable_d = i_wdata[`SCIG_IRQ_W-1:0];
    end else if (wr_ena_set) begin
      enable_d = enable_q | i_wdata[`SCIG_IRQ_W-1:0];
    end else if (wr_ena_clr) begin
      enable_d = enable_q & ~i_wdata[`SCIG_IRQ_W-1:0];
    end
  end

  // Interrupt enables
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      enable_q <= '0;
    end else begin
      enable_q <= enable_d;
    end
  end

  // Interrupt line from enabled pending sources only
  assign o_irq = |masked;

  // Fast-bus path next state: bit 31 set enables, clear disables, one capable port per write
  always_comb begin
    fast_d = fast_q;
    if (fast_ok) begin
      if (i_wdata[31]) begin
        fast_d = fast_q | i_wdata[NUM_PORTS-1:0];
      end else begin
        fast_d = fast_q & ~i_wdata[NUM_PORTS-1:0];
      end
    end
  end

  // Fast-bus path state
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      fast_q <= '0;
    end else begin
      fast_q <= fast_d;
    end
  end

  // Port access grant: each port answers on exactly one bus aperture
  assign o_port_apb_grant = i_port_apb_sel & ~fast_q;
  assign o_port_ahb_grant = i_port_ahb_sel & fast_q;
  assign o_port_fast_path = fast_q;

  // Regulator setting; out-of-range codes are ignored
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      regulator_q <= `SCIG_REG_DEFAULT;
    end else if (reg_ok) begin
      regulator_q <= i_wdata[`SCIG_REG_W-1:0];
    end
  end
  assign o_regulator_setting = regulator_q;

  // Clock gating enable, off after reset
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      gating_q <= 1'b0;
    end else if (wr_gating) begin
      gating_q <= i_wdata[0];
    end
  end

  // Status view select: 0 raw, 1 masked
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      view_q <= 1'b0;
    end else if (wr_view) begin
      view_q <= i_wdata[0];
    end
  end

  // Per-peripheral run enables
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      run_en_q <= '0;
    end else if (wr_run_en) begin
      run_en_q <= i_wdata[NUM_PERIPH-1:0];
    end
  end

  // Per-peripheral sleep enables, kept whether or not gating is on
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      sleep_en_q <= '0;
    end else if (wr_sleep_en) begin
      sleep_en_q <= i_wdata[NUM_PERIPH-1:0];
    end
  end

  // Per-peripheral deep-sleep enables, kept whether or not gating is on
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      dsleep_en_q <= '0;
    end else if (wr_dsleep_en) begin
      dsleep_en_q <= i_wdata[NUM_PERIPH-1:0];
    end
  end

  // Power mode seen by the gating logic; deep-sleep wins over sleep
  always_comb begin
    if (i_deep_sleep) begin
      power_mode = SCIG_MODE_DSLEEP;
    end else if (i_sleep) begin
      power_mode = SCIG_MODE_SLEEP;
    end else begin
      power_mode = SCIG_MODE_RUN;
    end
  end

  // Gating configuration to the clock-enable module
  assign gate_bus.gating_enable = gating_q;
  assign gate_bus.mode          = power_mode;
  assign gate_bus.run_en        = run_en_q;
  assign gate_bus.sleep_en      = sleep_en_q;
  assign gate_bus.dsleep_en     = dsleep_en_q;

  scig_clock_gate #(.NUM_PERIPH(NUM_PERIPH)) u_gate (
    .i_clock (i_clock),
    .i_nrst  (i_nrst),
    .gate    (gate_bus)
  );
  assign o_periph_clk_en = gate_bus.clk_en;

  // Read word for the addressed register; zero for unmapped offsets and when no read
  always_comb begin
    rdata_d = '0;
    if (bus_op == SCIG_BUS_READ) begin
      case (i_addr)
        `SCIG_OFF_RAW_STATUS:  rdata_d = zext_irq(view_q ? masked : pending_q);
        `SCIG_OFF_MASK_STATUS: rdata_d = zext_irq(masked);
        `SCIG_OFF_IRQ_ENABLE:  rdata_d = zext_irq(enable_q);
        `SCIG_OFF_FAST_BUS:    rdata_d = 32'(fast_q);
        `SCIG_OFF_REGULATOR:   rdata_d = 32'(regulator_q);
        `SCIG_OFF_GATING:      rdata_d = {31'h0, gating_q};
        `SCIG_OFF_RUN_EN:      rdata_d = 32'(run_en_q);
        `SCIG_OFF_SLEEP_EN:    rdata_d = 32'(sleep_en_q);
        `SCIG_OFF_DSLEEP_EN:   rdata_d = 32'(dsleep_en_q);
        `SCIG_OFF_STATUS_VIEW: rdata_d = {31'h0, view_q};
        default:               rdata_d = '0;
      endcase
    end
  end

  // Read data, valid only in the cycle after the read strobe
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end
  assign o_rdata = rdata_q;
endmodule
`default_nettype wire

// ---- src/scig_defs.svh ----
// Register offsets, field positions, reset values and counts for the system-control block
`ifndef SCIG_DEFS_SVH
`define SCIG_DEFS_SVH

// Register word offsets (byte addresses)
`define SCIG_OFF_RAW_STATUS   8'h00
`define SCIG_OFF_MASK_STATUS  8'h04
`define SCIG_OFF_IRQ_ENABLE   8'h08
`define SCIG_OFF_IRQ_ENA_SET  8'h0c
`define SCIG_OFF_IRQ_ENA_CLR  8'h10
`define SCIG_OFF_IRQ_CLEAR    8'h14
`define SCIG_OFF_FAST_BUS     8'h18
`define SCIG_OFF_REGULATOR    8'h1c
`define SCIG_OFF_GATING       8'h20
`define SCIG_OFF_RUN_EN       8'h24
`define SCIG_OFF_SLEEP_EN     8'h28
`define SCIG_OFF_DSLEEP_EN    8'h2c
`define SCIG_OFF_STATUS_VIEW  8'h30

// Interrupt source bit positions
`define SCIG_BIT_MAIN_OSC     0
`define SCIG_BIT_FREQ_SYNTH   1
`define SCIG_BIT_BROWNOUT     2
`define SCIG_IRQ_W            3

// Ports with a selectable fast path: A B C E F H (bit index = port letter)
`define SCIG_FAST_CAPABLE     8'hb7

// Regulator setting: 0 = 2.25 V, steps of 0.05 V up to 10 = 2.75 V; default 2.50 V
`define SCIG_REG_W            4
`define SCIG_REG_DEFAULT      4'h5
`define SCIG_REG_MAX          4'ha

`endif

// ---- src/scig_pkg.sv ----
// Types shared by the system-control block
package scig_pkg;
  typedef enum logic [1:0] {
    SCIG_MODE_RUN,
    SCIG_MODE_SLEEP,
    SCIG_MODE_DSLEEP
  } scig_power_mode_t;

  typedef enum logic [1:0] {
    SCIG_BUS_IDLE,
    SCIG_BUS_WRITE,
    SCIG_BUS_READ
  } scig_bus_op_t;
endpackage

// ---- src/scig_gate_if.sv ----
// Interface carrying clock-gating configuration from the register bank to the gating module
`timescale 1ns/1ps
`default_nettype none
interface scig_gate_if #(
  parameter int NUM_PERIPH = 32
);
  import scig_pkg::*;
  logic                  gating_enable;
  scig_power_mode_t      mode;
  logic [NUM_PERIPH-1:0] run_en;
  logic [NUM_PERIPH-1:0] sleep_en;
  logic [NUM_PERIPH-1:0] dsleep_en;
  logic [NUM_PERIPH-1:0] clk_en;

  modport bank (output gating_enable, output mode, output run_en, output sleep_en, output dsleep_en,
                input clk_en);
  modport gate (input gating_enable, input mode, input run_en, input sleep_en, input dsleep_en,
                output clk_en);
endinterface
`default_nettype wire

// ---- src/scig_clock_gate.sv ----
// Peripheral clock-enable selection for run, sleep and deep-sleep
`timescale 1ns/1ps
`default_nettype none
module scig_clock_gate
  import scig_pkg::*;
#(
  parameter int NUM_PERIPH = 32
) (
  input  wire logic i_clock,
  input  wire logic i_nrst,
  scig_gate_if.gate gate
);
  logic [NUM_PERIPH-1:0] clk_en_q;

  // Registered per-peripheral clock enable; state of a stopped peripheral is kept by its own flops
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      clk_en_q <= '0;
    end else begin
      case (gate.mode)
        SCIG_MODE_RUN: begin
          clk_en_q <= gate.run_en;
        end
        SCIG_MODE_SLEEP: begin
          clk_en_q <= gate.gating_enable ? (gate.run_en & gate.sleep_en) : gate.run_en;
        end
        SCIG_MODE_DSLEEP: begin
          clk_en_q <= gate.gating_enable ? (gate.run_en & gate.dsleep_en) : gate.run_en;
        end
        default: begin
          clk_en_q <= gate.run_en;
        end
      endcase
    end
  end

  assign gate.clk_en = clk_en_q;
endmodule
`default_nettype wire

// ---- test/scig_top_monitor.sv ----
// Port-level checker for the system-control register bank
`timescale 1ns/1ps
`default_nettype none
`include "scig_defs.svh"
module scig_top_monitor #(
  parameter int NUM_PERIPH = 32,
  parameter int NUM_PORTS  = 8
) (
  input wire logic                  i_clock,
  input wire logic                  i_nrst,
  input wire logic [7:0]            i_addr,
  input wire logic [31:0]           i_wdata,
  input wire logic                  i_wr,
  input wire logic                  i_rd,
  input wire logic [31:0]           o_rdata,
  input wire logic                  i_main_osc_powerup_irq,
  input wire logic                  i_freq_synth_lock_irq,
  input wire logic                  i_brownout_irq,
  input wire logic                  o_irq,
  input wire logic [NUM_PORTS-1:0]  i_port_apb_sel,
  input wire logic [NUM_PORTS-1:0]  i_port_ahb_sel,
  input wire logic [NUM_PORTS-1:0]  o_port_apb_grant,
  input wire logic [NUM_PORTS-1:0]  o_port_ahb_grant,
  input wire logic [NUM_PORTS-1:0]  o_port_fast_path,
  input wire logic [`SCIG_REG_W-1:0] o_regulator_setting
);
  wire logic ev = i_main_osc_powerup_irq | i_freq_synth_lock_irq | i_brownout_irq;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_nrst);
  // Bus routing follows the fast-path state
  a_apb_route: assert property (o_port_apb_grant == (i_port_apb_sel & ~o_port_fast_path)) else $error("apb grant");
  a_ahb_route: assert property (o_port_ahb_grant == (i_port_ahb_sel & o_port_fast_path)) else $error("ahb grant");
  a_fast_capable: assert property ((o_port_fast_path & ~`SCIG_FAST_CAPABLE) == 8'h00) else $error("bad port");
  // Interrupt line needs a cause and drops on disable or clear
  a_irq_cause: assert property ($rose(o_irq) |-> $past(i_wr) || $past(ev)) else $error("irq no cause");
  a_disable_all: assert property (i_wr && i_addr == 8'h10 && i_wdata[2:0] == 3'h7 |=> !o_irq) else $error("irq");
  a_clear_all: assert property (i_wr && i_addr == 8'h14 && i_wdata[2:0] == 3'h7 && !ev |=> !o_irq) else $error("clr");
  // Masked status agrees with the line; read data only after a read
  a_masked_view: assert property (i_rd && i_addr == 8'h04 |=> (o_rdata == 32'h0) == !$past(o_irq)) else $error("mask");
  a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 32'h0) else $error("rdata idle");
  a_reg_range: assert property (o_regulator_setting <= `SCIG_REG_MAX) else $error("reg range");
  a_reg_default: assert property (!$past(i_nrst) |-> o_regulator_setting == `SCIG_REG_DEFAULT) else $error("reg rst");
  c_irq: cover property (o_irq);
  c_fast: cover property (o_port_fast_path != 8'h00);
  c_reg_max: cover property (o_regulator_setting == `SCIG_REG_MAX);
endmodule
bind scig_top scig_top_monitor #(.NUM_PERIPH(NUM_PERIPH), .NUM_PORTS(NUM_PORTS)) i_scig_top_monitor (.i_clock,
  .i_nrst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_main_osc_powerup_irq, .i_freq_synth_lock_irq,
  .i_brownout_irq, .o_irq, .i_port_apb_sel, .i_port_ahb_sel, .o_port_apb_grant, .o_port_ahb_grant,
  .o_port_fast_path, .o_regulator_setting);
`default_nettype wire

// ---- test/scig_cpu_model.sv ----
// Processor-side bus master issuing register reads and writes
`timescale 1ns/1ps
`default_nettype none
module scig_cpu_model (
  input  wire logic        i_clock,
  input  wire logic [31:0] i_rdata,
  output var logic  [7:0]  o_addr,
  output var logic  [31:0] o_wdata,
  output var logic         o_wr,
  output var logic         o_rd
);
  // Idle bus at time zero
  initial begin
    o_addr = 8'h00;
    o_wdata = 32'h0;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end
  // One-cycle write; data scrambled once released
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clock);
    o_addr  <= a;
    o_wdata <= d;
    o_wr    <= 1'b1;
    @(posedge i_clock);
    o_wr    <= 1'b0;
    o_wdata <= ~d;
  endtask
  // One-cycle read; data taken once settled in the next cycle
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_clock);
    o_addr <= a;
    o_rd   <= 1'b1;
    @(posedge i_clock);
    o_rd   <= 1'b0;
    #1;
    d = i_rdata;
  endtask
endmodule
`default_nettype wire

// ---- test/tb_scig_top.sv ----
// Self-checking bench for the system-control register bank
`timescale 1ns/1ps
`default_nettype none
module tb_scig_top;
  logic        i_clock = 1'b0, i_nrst = 1'b0, i_wr, i_rd, o_irq, i_sleep = 1'b0, i_deep_sleep = 1'b0;
  logic        i_main_osc_powerup_irq = 1'b0, i_freq_synth_lock_irq = 1'b0, i_brownout_irq = 1'b0;
  logic [7:0]  i_addr, i_port_apb_sel = 8'hff, i_port_ahb_sel = 8'hff;
  logic [7:0]  o_port_apb_grant, o_port_ahb_grant, o_port_fast_path;
  logic [3:0]  o_regulator_setting;
  logic [31:0] i_wdata, o_rdata, o_periph_clk_en, r;
  int          err_count = 0, compares = 0, cyc = 0;
  scig_top i_scig_top (.i_clock, .i_nrst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_main_osc_powerup_irq,
    .i_freq_synth_lock_irq, .i_brownout_irq, .o_irq, .i_sleep, .i_deep_sleep, .i_port_apb_sel, .i_port_ahb_sel,
    .o_port_apb_grant, .o_port_ahb_grant, .o_port_fast_path, .o_regulator_setting, .o_periph_clk_en);
  scig_cpu_model i_scig_cpu_model (.i_clock, .i_rdata(o_rdata), .o_addr(i_addr), .o_wdata(i_wdata),
    .o_wr(i_wr), .o_rd(i_rd));
  always #12.5 i_clock = ~i_clock;
  // Cut a hang short
  always @(posedge i_clock) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      conclude();
    end
  end
  task conclude();
    if (err_count == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task w(input logic [7:0] a, input logic [31:0] d);
    i_scig_cpu_model.wr(a, d);
    #1;
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] e);
    i_scig_cpu_model.rd(a, r);
    chk(r, e);
  endtask
  // One-cycle event pulse on one source
  task pulse(input int b);
    @(posedge i_clock);
    {i_brownout_irq, i_freq_synth_lock_irq, i_main_osc_powerup_irq} <= 3'h1 << b;
    @(posedge i_clock);
    {i_brownout_irq, i_freq_synth_lock_irq, i_main_osc_powerup_irq} <= 3'h0;
  endtask
  task mode(input logic s, input logic d);
    @(posedge i_clock);
    i_sleep <= s;
    i_deep_sleep <= d;
    repeat (3) @(posedge i_clock);
    #1;
  endtask
  initial begin
    repeat (20) @(posedge i_clock);
    i_nrst <= 1'b1;
    rdc(8'h1c, 32'h5);
    rdc(8'h20, 32'h0);
    w(8'h1c, 32'ha);
    w(8'h1c, 32'hb);
    rdc(8'h1c, 32'ha);
    chk({28'h0, o_regulator_setting}, 32'ha);
    // Fast path on port A, then refused requests, then off
    w(8'h18, 32'h8000_0001);
    chk({24'h0, o_port_ahb_grant}, 32'h01);
    chk({24'h0, o_port_apb_grant}, 32'hfe);
    w(8'h18, 32'h8000_0006);
    w(8'h18, 32'h8000_0008);
    chk({24'h0, o_port_fast_path}, 32'h01);
    w(8'h18, 32'h0000_0001);
    chk({24'h0, o_port_apb_grant}, 32'hff);
    chk({24'h0, o_port_ahb_grant}, 32'h00);
    // Each source: pend, enable, views, disable, clear
    for (int b = 0; b < 3; b++) begin
      pulse(b);
      rdc(8'h00, 32'h1 << b);
      chk({31'h0, o_irq}, 32'h0);
      w(8'h0c, 32'h1 << b);
      chk({31'h0, o_irq}, 32'h1);
      rdc(8'h04, 32'h1 << b);
      w(8'h10, 32'h7);
      chk({31'h0, o_irq}, 32'h0);
      w(8'h30, 32'h1);
      rdc(8'h00, 32'h0);
      w(8'h30, 32'h0);
      w(8'h14, 32'h1 << b);
      rdc(8'h00, 32'h0);
    end
    pulse(0);
    pulse(2);
    w(8'h14, 32'h1);
    rdc(8'h00, 32'h4);
    w(8'h0c, 32'h1);
    w(8'h0c, 32'h4);
    w(8'h10, 32'h1);
    rdc(8'h08, 32'h4);
    chk({31'h0, o_irq}, 32'h1);
    w(8'h14, 32'h7);
    chk({31'h0, o_irq}, 32'h0);
    // Clear and event in one cycle: the event wins
    fork
      pulse(1);
      w(8'h14, 32'h2);
    join
    rdc(8'h00, 32'h2);
    w(8'h14, 32'h2);
    rdc(8'h00, 32'h0);
    // Peripheral clocks across modes, gating off then on
    w(8'h24, 32'h3);
    w(8'h28, 32'h1);
    w(8'h2c, 32'h2);
    mode(1'b1, 1'b0);
    chk(o_periph_clk_en, 32'h3);
    mode(1'b0, 1'b1);
    chk(o_periph_clk_en, 32'h3);
    w(8'h20, 32'h1);
    mode(1'b0, 1'b1);
    chk(o_periph_clk_en, 32'h2);
    mode(1'b1, 1'b0);
    chk(o_periph_clk_en, 32'h1);
    mode(1'b0, 1'b0);
    chk(o_periph_clk_en, 32'h3);
    rdc(8'h2c, 32'h2);
    conclude();
  end
endmodule
`default_nettype wire
